// ---- testbench/spp_rd_sink.sv ----
// read-side consumer model facing the memory port's output buffer
// assumes the port's core_clk and rstn; hold comes from the testbench
`default_nettype none

module spp_rd_sink (
  input  wire  logic        core_clk,
  input  wire  logic        rstn,
  input  wire  logic [35:0] dqOut,
  input  wire  logic        readValid,
  output logic              readReady,
  input  wire  logic        hold
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [35:0] words[$];
  time         stamps[$];

  // ready only moves off the sampling edge, so a pop never races the head word
  always @(negedge core_clk or negedge rstn) begin
    if (!rstn) readReady <= 1'b0;
    else readReady <= !hold;
  end

  // popped words are logged with their edge time
  always @(posedge core_clk) begin
    if (rstn && readValid === 1'b1 && readReady === 1'b1) begin
      words.push_back(dqOut);
      stamps.push_back($time);
    end
  end
endmodule

`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the pipelined burst memory port
// assumes the wide variant: 18-bit address, four 9-bit lanes
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                core_clk = 1'b0;
  logic                rstn = 1'b0;
  logic [17:0]         addr = 18'h0;
  logic [35:0]         dqIn = 36'h0;
  logic [35:0]         dqOut;
  logic                dqOe, readValid, readReady, readStall;
  logic                csN = 1'b1, dsHigh = 1'b0, dsLowN = 1'b1, psN = 1'b1, ctN = 1'b1, advN = 1'b1;
  logic [3:0]          wsN = 4'hf;
  logic                weN = 1'b1, gwN = 1'b1, oeN = 1'b0, sleep = 1'b0, hold = 1'b0;
  spp_pkg::spp_order_e ord = spp_pkg::SPP_ORDER_INTERLEAVED;
  logic [35:0]         mem[int];
  time                 capT;
  int                  errCount = 0, nCompared = 0;

  always #(spp_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  spp_port dut (.core_clk(core_clk), .rstn(rstn), .addr(addr), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
    .pipelinedChipSelectN(csN), .depthSelectHigh(dsHigh), .depthSelectLowN(dsLowN),
    .processorAddrStrobeN(psN), .controllerAddrStrobeN(ctN), .burstAdvanceN(advN),
    .laneWriteSelectN(wsN), .laneWriteEnableN(weN), .allLanesWriteN(gwN), .burstOrder(ord),
    .outputEnableN(oeN), .sleepRequest(sleep), .readValid(readValid), .readReady(readReady),
    .readStall(readStall));

  spp_rd_sink sink (.core_clk(core_clk), .rstn(rstn), .dqOut(dqOut), .readValid(readValid),
    .readReady(readReady), .hold(hold));

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic chkD(input logic [35:0] got, input logic [35:0] exp);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkT(input logic [63:0] got, input logic [63:0] exp);
    chkD(36'(got), 36'(exp));
  endtask

  task automatic finalReport();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus cycle: drive at the falling edge, hold while the pipeline stalls
  // ----------------------------------------------------------------
  // address and enables presented with the strobe and advance pins as given
  task automatic cyc(input logic ps, input logic ct, input logic burst_advance_n, input logic [2:0] ce,
                     input logic [17:0] a, input logic [35:0] d, input logic gw, input logic we,
                     input logic [3:0] ws);
    logic st;
    int   n;
    @(negedge core_clk);
    {psN, ctN, advN, addr, dqIn, gwN, weN, wsN} = {ps, ct, burst_advance_n, a, d, gw, we, ws};
    {csN, dsHigh, dsLowN} = {!ce[2], ce[1], !ce[0]};
    n = 0;
    do begin
      #3 st = readStall;
      @(posedge core_clk);
      capT = $time;
      if (st) @(negedge core_clk);
      n++;
    end while (st && n < 200);
  endtask

  // lanes chosen by the controller; deselect right after
  task automatic wr(input logic [17:0] a, input logic [35:0] d, input logic gw, input logic we,
                    input logic [3:0] ws, input logic viaCtl);
    logic [3:0] m;
    m = !gw ? 4'hf : (!we ? ~ws : 4'h0);
    cyc(viaCtl, !viaCtl, 1'b1, 3'h7, a, d, gw, we, ws);
    cyc(1'b1, 1'b0, 1'b1, 3'h6, ~a, ~d, 1'b1, 1'b1, 4'hf);
    for (int i = 0; i < 4; i++) if (m[i]) mem[a][9*i +: 9] = d[9*i +: 9];
  endtask

  task automatic waitWords(input int n);
    for (int k = 0; k < 60 && sink.words.size() < n; k++) @(negedge core_clk);
  endtask

  // strobe, three advances, deselect; four words in burst order
  task automatic rd(input logic [17:0] a, input spp_pkg::spp_order_e o, input logic viaCtl, input logic timed);
    time        t0;
    logic [1:0] s;
    @(negedge core_clk);
    ord = o;
    cyc(viaCtl, !viaCtl, 1'b1, 3'h7, a, 36'h0, 1'b1, 1'b1, 4'hf);
    t0 = capT;
    repeat (3) cyc(1'b1, 1'b1, 1'b0, 3'h7, ~a, 36'hfffffffff, 1'b1, 1'b1, 4'hf);
    cyc(1'b1, 1'b0, 1'b1, 3'h3, a, 36'h0, 1'b1, 1'b1, 4'hf);
    waitWords(4);
    chkD(36'(sink.words.size()), 36'h4);
    for (int i = 0; i < 4 && sink.words.size() > 0; i++) begin
      s = (o == spp_pkg::SPP_ORDER_LINEAR) ? a[1:0] + 2'(i) : a[1:0] ^ 2'(i);
      chkD(sink.words.pop_front(), mem[{a[17:2], s}]);
      if (!timed && i == 0) t0 = sink.stamps[0] - spp_pkg::READ_LATENCY * spp_pkg::CLK_PERIOD_NS;
      chkT(sink.stamps.pop_front(), t0 + (spp_pkg::READ_LATENCY + i) * spp_pkg::CLK_PERIOD_NS);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic tAllLanes();
    for (int i = 0; i < 4; i++) wr(18'h100 + 18'(i), 36'h111111111 * (i + 1), 1'b0, 1'b1, 4'hf, i[0]);
    rd(18'h102, spp_pkg::SPP_ORDER_INTERLEAVED, 1'b0, 1'b1);
    rd(18'h101, spp_pkg::SPP_ORDER_LINEAR, 1'b1, 1'b1);
    $display("test all_lanes done");
  endtask

  task automatic tLanes();
    wr(18'h101, 36'habcdef012, 1'b1, 1'b0, 4'h5, 1'b0);
    wr(18'h102, 36'h987654321, 1'b1, 1'b1, 4'h0, 1'b1);
    // selects without enable make a plain read of the untouched word
    waitWords(1);
    chkD(36'(sink.words.size()), 36'h1);
    if (sink.words.size() > 0) chkD(sink.words.pop_front(), mem[18'h102]);
    sink.words.delete();
    sink.stamps.delete();
    wr(18'h103, 36'h0f0f0f0f0, 1'b0, 1'b1, 4'hf, 1'b1);
    rd(18'h103, spp_pkg::SPP_ORDER_LINEAR, 1'b1, 1'b1);
    $display("test lanes done");
  endtask

  task automatic tStall();
    @(negedge core_clk);
    hold = 1'b1;
    fork
      rd(18'h100, spp_pkg::SPP_ORDER_INTERLEAVED, 1'b0, 1'b0);
      begin
        repeat (10) @(negedge core_clk);
        chkD(36'({readStall, readValid, dqOe}), 36'h7);
        sleep = 1'b1;
        #1 chkD(36'(dqOe), 36'h0);
        sleep = 1'b0;
        oeN = 1'b1;
        #1 chkD(36'(dqOe), 36'h0);
        oeN = 1'b0;
        hold = 1'b0;
      end
    join
    $display("test stall done");
  endtask

  // four advances: the counter wraps back to the start word
  task automatic tWrap();
    ord = spp_pkg::SPP_ORDER_INTERLEAVED;
    cyc(1'b0, 1'b1, 1'b1, 3'h7, 18'h102, 36'h0, 1'b1, 1'b1, 4'hf);
    repeat (4) cyc(1'b1, 1'b1, 1'b0, 3'h7, 18'h0, 36'h0, 1'b1, 1'b1, 4'hf);
    cyc(1'b1, 1'b0, 1'b1, 3'h3, 18'h0, 36'h0, 1'b1, 1'b1, 4'hf);
    waitWords(5);
    chkD(36'(sink.words.size()), 36'h5);
    for (int i = 0; i < 5 && sink.words.size() > 0; i++) begin
      chkD(sink.words.pop_front(), mem[18'h100 | 18'(2'h2 ^ 2'(i))]);
    end
    sink.words.delete();
    sink.stamps.delete();
    $display("test wrap done");
  endtask

  task automatic tDeselect();
    for (int k = 0; k < 3; k++) begin
      cyc(1'b1, 1'b0, 1'b1, 3'h7, 18'h102, 36'h0, 1'b1, 1'b1, 4'hf);
      cyc(1'b1, 1'b0, 1'b1, 3'h7 ^ (3'h1 << k), 18'h100, 36'h0, 1'b1, 1'b1, 4'hf);
      repeat (3) cyc(1'b1, 1'b1, 1'b0, 3'h7, 18'h0, 36'h0, 1'b1, 1'b1, 4'hf);
      repeat (8) @(negedge core_clk);
      chkD(36'(sink.words.size()), 36'h1);
      if (sink.words.size() > 0) chkD(sink.words.pop_front(), mem[18'h102]);
      sink.words.delete();
      sink.stamps.delete();
    end
    $display("test deselect done");
  endtask

  initial begin
    repeat (5) @(negedge core_clk);
    chkD(36'({readValid, dqOe, readStall}), 36'h0);
    chkD(dqOut, 36'h0);
    rstn = 1'b1;
    tAllLanes();
    tLanes();
    tStall();
    tWrap();
    tDeselect();
    finalReport();
  end

  // a hang is cut short well past the hundred-odd cycles the tests need
  initial begin
    #(4000 * spp_pkg::CLK_PERIOD_NS);
    errCount++;
    finalReport();
  end
endmodule

`default_nettype wire

// ---- verilog/spp_pkg.sv ----
// constants shared by the pipelined burst static memory port
// assumes a single 125 MHz core clock and an active-low asynchronous reset
//
// Functional notes
// - every synchronous input is captured into input registers on the rising clock edge; the port holds them instead while readStall is high.
// - a new address and the chip enables are latched only when either address strobe is low.
// - after a latched address, later burst addresses come from a two-bit counter stepped by the advance input.
// - the burst order is selectable between interleaved and linear.
// - a write registers address, data and write controls and then completes with no further handshake.
// - a write updates any combination of the four bytes as chosen by the per-byte write selects.
// - a low global write writes every byte lane whatever the byte selects say.
// - output enable and sleep act asynchronously and are never captured by the input registers.
// - burst reads deliver the first word after three clocks and each following word one clock later.
// - deselecting through the chip enables takes effect within one clock.
// - read data passes through output registers two stages behind the registered inputs.
// - the array is 36-bit words on an 18-bit address or 18-bit words on a 19-bit address.
// - the two lowest address bits load the burst counter when an address is latched.
// - byte write selects take effect only when the byte write enable is low on the same edge.
`default_nettype none

package spp_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned READ_LATENCY  = 3;

  // ----------------------------------------------------------------
  // array organisation (wide variant by default)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 18;
  localparam int unsigned LANE_COUNT = 4;
  localparam int unsigned LANE_W     = 9;
  localparam int unsigned BURST_W    = 2;
  localparam int unsigned FIFO_DEPTH = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CNT_RESET = 2'h0;
  localparam logic       SEL_RESET = 1'b0;
  localparam logic       PIN_IDLE  = 1'b1;

  typedef enum logic {SPP_ORDER_INTERLEAVED, SPP_ORDER_LINEAR} spp_order_e;

endpackage

`default_nettype wire

// ---- verilog/spp_port.sv ----
// synchronous bus port and array of a pipelined burst static memory
// assumes the controller obeys the strobe protocol and watches readStall
`default_nettype none

module spp_port #(
  parameter int unsigned ADDR_W = spp_pkg::ADDR_W,
  parameter int unsigned LANES  = spp_pkg::LANE_COUNT,
  parameter int unsigned LANE_W = spp_pkg::LANE_W
) (
  input  wire  logic                      core_clk,
  input  wire  logic                      rstn,
  input  wire  logic [ADDR_W-1:0]         addr,
  input  wire  logic [LANES*LANE_W-1:0]   dqIn,
  output logic       [LANES*LANE_W-1:0]   dqOut,
  output logic                            dqOe,
  input  wire  logic                      pipelinedChipSelectN,
  input  wire  logic                      depthSelectHigh,
  input  wire  logic                      depthSelectLowN,
  input  wire  logic                      processorAddrStrobeN,
  input  wire  logic                      controllerAddrStrobeN,
  input  wire  logic                      burstAdvanceN,
  input  wire  logic [LANES-1:0]          laneWriteSelectN,
  input  wire  logic                      laneWriteEnableN,
  input  wire  logic                      allLanesWriteN,
  input  wire  spp_pkg::spp_order_e       burstOrder,
  input  wire  logic                      outputEnableN,
  input  wire  logic                      sleepRequest,
  output logic                            readValid,
  input  wire  logic                      readReady,
  output logic                            readStall
);

  localparam int unsigned WORD_W = LANES * LANE_W;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // word and depth from parameters
  logic [WORD_W-1:0]     mem [2**ADDR_W];
  logic [ADDR_W-1:0]     addrIn_q, addrIn_d;
  logic [WORD_W-1:0]     dataIn_q, dataIn_d;
  logic                  ce1N_q, ce1N_d, ce2_q, ce2_d, ce3N_q, ce3N_d;
  logic                  procStbN_q, procStbN_d, ctrlStbN_q, ctrlStbN_d, advN_q, advN_d;
  logic [LANES-1:0]      laneSelN_q, laneSelN_d;
  logic                  laneEnN_q, laneEnN_d, allWrN_q, allWrN_d;
  logic                  selected_q, selected_d;
  logic [ADDR_W-1:2]     addrHigh_q, addrHigh_d;
  logic [1:0]            base_q, base_d, cnt_q, cnt_d;
  logic [WORD_W-1:0]     rdWord_q, rdWord_d;
  logic                  rdValid_q, rdValid_d;
  logic [WORD_W-1:0]     buf0_q, buf0_d, buf1_q, buf1_d;
  logic [1:0]            fill_q, fill_d;

  logic                  strobe, chipOn, newAddrGo, deselectGo, advanceGo, accessGo;
  logic                  writeGo, readGo, push, pop, stall;
  logic [LANES-1:0]      laneMask;
  logic [ADDR_W-1:0]     accAddr;

  function automatic logic [1:0] burstOffset(input logic [1:0] start, input logic [1:0] step,
                                             input spp_pkg::spp_order_e order);
    // both orders stay inside the aligned four-word group
    burstOffset = (order == spp_pkg::SPP_ORDER_LINEAR) ? 2'(start + step) : (start ^ step);
  endfunction

  // ----------------------------------------------------------------
  // input registers
  // ----------------------------------------------------------------
  // a stalled access is held so that no read word is lost to a full buffer
  always_comb begin
    addrIn_d   = addrIn_q;
    dataIn_d   = dataIn_q;
    ce1N_d     = ce1N_q;
    ce2_d      = ce2_q;
    ce3N_d     = ce3N_q;
    procStbN_d = procStbN_q;
    ctrlStbN_d = ctrlStbN_q;
    advN_d     = advN_q;
    laneSelN_d = laneSelN_q;
    laneEnN_d  = laneEnN_q;
    allWrN_d   = allWrN_q;
    if (!stall) begin
      addrIn_d   = addr;
      dataIn_d   = dqIn;
      ce1N_d     = pipelinedChipSelectN;
      ce2_d      = depthSelectHigh;
      ce3N_d     = depthSelectLowN;
      procStbN_d = processorAddrStrobeN;
      ctrlStbN_d = controllerAddrStrobeN;
      advN_d     = burstAdvanceN;
      laneSelN_d = laneWriteSelectN;
      laneEnN_d  = laneWriteEnableN;
      allWrN_d   = allLanesWriteN;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      addrIn_q   <= '0;
      dataIn_q   <= '0;
      ce1N_q     <= spp_pkg::PIN_IDLE;
      ce2_q      <= 1'b0;
      ce3N_q     <= spp_pkg::PIN_IDLE;
      procStbN_q <= spp_pkg::PIN_IDLE;
      ctrlStbN_q <= spp_pkg::PIN_IDLE;
      advN_q     <= spp_pkg::PIN_IDLE;
      laneSelN_q <= '1;
      laneEnN_q  <= spp_pkg::PIN_IDLE;
      allWrN_q   <= spp_pkg::PIN_IDLE;
    end else begin
      addrIn_q   <= addrIn_d;
      dataIn_q   <= dataIn_d;
      ce1N_q     <= ce1N_d;
      ce2_q      <= ce2_d;
      ce3N_q     <= ce3N_d;
      procStbN_q <= procStbN_d;
      ctrlStbN_q <= ctrlStbN_d;
      advN_q     <= advN_d;
      laneSelN_q <= laneSelN_d;
      laneEnN_q  <= laneEnN_d;
      allWrN_q   <= allWrN_d;
    end
  end

  // ----------------------------------------------------------------
  // access decode and burst counter
  // ----------------------------------------------------------------
  // sleep gates accesses straight from the pin, never through a register
  always_comb begin
    strobe     = !procStbN_q || !ctrlStbN_q;
    chipOn     = !ce1N_q && ce2_q && !ce3N_q;
    newAddrGo  = strobe && chipOn && !stall && !sleepRequest;
    deselectGo = strobe && !chipOn && !stall;
    advanceGo  = !strobe && !advN_q && selected_q && !stall && !sleepRequest;
    accessGo   = newAddrGo || (!strobe && selected_q && !stall && !sleepRequest);
    laneMask   = laneEnN_q ? '0 : ~laneSelN_q;
    if (!allWrN_q) begin
      laneMask = '1;
    end
    writeGo    = accessGo && (laneMask != '0);
    readGo     = accessGo && (laneMask == '0);
    selected_d = newAddrGo ? 1'b1 : (deselectGo ? 1'b0 : selected_q);
    addrHigh_d = addrHigh_q;
    base_d     = base_q;
    cnt_d      = cnt_q;
    if (newAddrGo) begin
      addrHigh_d = addrIn_q[ADDR_W-1:2];
      base_d     = addrIn_q[1:0];
      cnt_d      = spp_pkg::CNT_RESET;
    end else if (advanceGo) begin
      cnt_d = 2'(cnt_q + 2'h1);
    end
    accAddr = newAddrGo ? addrIn_q : {addrHigh_q, burstOffset(base_q, cnt_d, burstOrder)};
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      selected_q <= spp_pkg::SEL_RESET;
      addrHigh_q <= '0;
      base_q     <= spp_pkg::CNT_RESET;
      cnt_q      <= spp_pkg::CNT_RESET;
    end else begin
      selected_q <= selected_d;
      addrHigh_q <= addrHigh_d;
      base_q     <= base_d;
      cnt_q      <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // array
  // ----------------------------------------------------------------
  // self-timed lane write
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (writeGo && laneMask[i]) begin
        mem[accAddr][i*LANE_W +: LANE_W] <= dataIn_q[i*LANE_W +: LANE_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // read pipeline and two-entry output buffer
  // ----------------------------------------------------------------
  always_comb begin
    readValid = (fill_q != 2'h0);
    pop       = readValid && readReady;
    push      = rdValid_q && (fill_q != 2'(spp_pkg::FIFO_DEPTH));
    stall     = rdValid_q && !push;
    readStall = stall;
    rdValid_d = stall ? rdValid_q : readGo;
    rdWord_d  = readGo ? mem[accAddr] : rdWord_q;
    fill_d    = 2'(fill_q + {1'b0, push} - {1'b0, pop});
    buf0_d    = buf0_q;
    buf1_d    = buf1_q;
    if (pop && fill_q == 2'h2) begin
      buf0_d = buf1_q;
      if (push) begin
        buf1_d = rdWord_q;
      end
    end else if (push && (fill_q == 2'h0 || (fill_q == 2'h1 && pop))) begin
      buf0_d = rdWord_q;
    end else if (push) begin
      buf1_d = rdWord_q;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdWord_q  <= '0;
      rdValid_q <= 1'b0;
      buf0_q    <= '0;
      buf1_q    <= '0;
      fill_q    <= 2'h0;
    end else begin
      rdWord_q  <= rdWord_d;
      rdValid_q <= rdValid_d;
      buf0_q    <= buf0_d;
      buf1_q    <= buf1_d;
      fill_q    <= fill_d;
    end
  end

  assign dqOe  = readValid && !outputEnableN && !sleepRequest;
  assign dqOut = buf0_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  logic [LANE_W-1:0] lane0Now;
  assign lane0Now = mem[accAddr][LANE_W-1:0];

  AST_CAPTURE: assert property (!stall |=> addrIn_q == $past(addr) && advN_q == $past(burstAdvanceN))
    else $error("input register did not capture the pins");
  AST_LATCH_STROBE: assert property (!newAddrGo |=> $stable(addrHigh_q) && $stable(base_q))
    else $error("address latched without a strobe");
  AST_COUNT_STEP: assert property (advanceGo |=> cnt_q == 2'($past(cnt_q) + 2'h1))
    else $error("burst counter did not step on advance");
  AST_ORDER_LINEAR: assert property (
    accessGo && !newAddrGo && burstOrder == spp_pkg::SPP_ORDER_LINEAR && cnt_d == 2'h1 |->
    accAddr[1:0] == 2'(base_q + 2'h1))
    else $error("linear order produced the wrong address");
  AST_ALL_LANES: assert property (writeGo && !allWrN_q |=> mem[$past(accAddr)] == $past(dataIn_q))
    else $error("global write missed a lane");
  AST_LANE_KEEP: assert property (writeGo && !laneMask[0] |=> mem[$past(accAddr)][LANE_W-1:0] == $past(lane0Now))
    else $error("unselected lane was written");
  AST_OE_ASYNC: assert property (dqOe |-> !outputEnableN && !sleepRequest && readValid)
    else $error("data driven while disabled");
  AST_LATENCY: assert property (readGo && fill_q == 2'h0 && !rdValid_q |-> ##2 readValid)
    else $error("first read word late");
  AST_DESELECT: assert property (deselectGo |=> !selected_q && !rdValid_q)
    else $error("deselect took more than one cycle");
  AST_PIPE_OUT: assert property (rdValid_q && fill_q == 2'h0 |=> dqOut == $past(rdWord_q))
    else $error("output register lost the read word");
  AST_LOAD_START: assert property (newAddrGo |=> base_q == $past(addrIn_q[1:0]) && cnt_q == 2'h0)
    else $error("start bits did not load the counter");
  AST_LANE_QUAL: assert property (laneEnN_q && allWrN_q |-> !writeGo)
    else $error("lane select acted without enable");
  AST_WRAP: assert property (advanceGo && cnt_q == 2'h3 |=> cnt_q == 2'h0)
    else $error("burst counter left its group");

  COV_BURST: cover property (newAddrGo && readGo ##1 advanceGo [*3]);
  COV_WRITE: cover property (writeGo && laneMask != '1);
  COV_STALL: cover property (stall ##1 !stall);
  COV_DESEL: cover property (deselectGo);

endmodule

`default_nettype wire
